/* File: hw/cgm_pkg.sv */
// constants shared by the glyph map controller and its test bench
// assumes a single 200 MHz clock and an 8-bit plain register port
package cgm_pkg;
  // register byte offsets
  localparam logic [7:0] CGM_OFF_STATUS    = 8'h00;
  localparam logic [7:0] CGM_OFF_CTRL      = 8'h04;
  localparam logic [7:0] CGM_OFF_GLYPH_ADR = 8'h08;
  localparam logic [7:0] CGM_OFF_GLYPH_DAT = 8'h0C;
  localparam logic [7:0] CGM_OFF_RAM_SEL   = 8'h10;
  // control register field positions
  localparam int CGM_CTRL_BLINK  = 0;
  localparam int CGM_CTRL_CURSOR = 1;
  localparam int CGM_CTRL_DISP   = 2;
  localparam int CGM_CTRL_SHIFT  = 3;
  localparam int CGM_CTRL_INC    = 4;
  localparam int CGM_CTRL_FONT   = 5;
  localparam int CGM_CTRL_LINES  = 6;
  localparam int CGM_CTRL_BUSW   = 7;
  // status register field positions
  localparam int CGM_STAT_BUSY = 7;
  localparam int CGM_STAT_SEL  = 6;
  // reset and init values
  localparam logic [7:0] CGM_CTRL_RST   = 8'h00;
  localparam logic [5:0] CGM_GADDR_RST  = 6'h00;
  localparam logic [4:0] CGM_ROW_ALL    = 5'h1F;
  localparam logic [2:0] CGM_CURSOR_ROW = 3'h7;
  // power-on init duration
  localparam int CGM_CLK_MHZ      = 200;
  localparam int CGM_INIT_TIME_US = 15000;
  localparam int CGM_INIT_CYCLES  = CGM_INIT_TIME_US * CGM_CLK_MHZ;
  localparam int CGM_CNT_W        = 22;
  // power-on sequence states
  typedef enum logic [5:0] {
    CGM_ST_CLEAR = 6'h01,
    CGM_ST_FUNC  = 6'h02,
    CGM_ST_DISP  = 6'h04,
    CGM_ST_ENTRY = 6'h08,
    CGM_ST_WAIT  = 6'h10,
    CGM_ST_IDLE  = 6'h20
  } cgm_state_t;
endpackage : cgm_pkg

/* File: hw/cgm_glyph_ram.sv */
// user glyph storage: one write port, two registered read ports
// assumes writer and both readers share the controller clock
module cgm_glyph_ram #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  input  wire logic [AW-1:0] rd_a_addr_in,
  output logic      [DW-1:0] rd_a_data_out,
  input  wire logic [AW-1:0] rd_b_addr_in,
  output logic      [DW-1:0] rd_b_data_out
);
  logic [DW-1:0] mem [2**AW];

  initial begin
    if (AW < 1 || DW < 5) $error("glyph ram too small");
  end

  // memory array carries no reset
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // old data on a read of the address written this cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_a_data_out <= '0;
      rd_b_data_out <= '0;
    end else begin
      rd_a_data_out <= mem[rd_a_addr_in];
      rd_b_data_out <= mem[rd_b_addr_in];
    end
  end
endmodule : cgm_glyph_ram

/* File: hw/cgm_ctrl.sv */
// glyph map and power-on init logic of a character display controller
// assumes register port and glyph fetch inputs come from logic on sys_clk_in
//
// Function
// - character code bits 2..0 form glyph memory address bits 5..3
// - glyph memory address bits 2..0 pick the pattern row
// - eighth row shows stored data ORed with the cursor
// - a one in the stored eighth row lights regardless of cursor
// - dot columns come from data bits 4..0, bit 4 leftmost
// - data bits 7..5 stored, not shown, readable and writable
// - user glyph only when code bits 7..4 are zero, else ROM
// - code bit 3 ignored, so 00 and 08 share a glyph
// - data bit one lights the dot, zero leaves it dark
// - power-on: clear, function, display control, entry mode, text memory selected
// - busy stays one for the whole 15 ms init, then clears
// - init selects 8-bit bus, one line, 5x7 font
// - init turns display, cursor and blink off
// - init sets address increment by one, no display shift
module cgm_ctrl #(
  parameter int INIT_CYCLES = cgm_pkg::CGM_INIT_CYCLES
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic [7:0] char_code_in,
  input  wire logic [2:0] pat_row_in,
  input  wire logic       cursor_here_in,
  output logic      [4:0] dots_out,
  output logic            rom_glyph_out,
  output logic      [7:0] rom_code_out,
  output logic            busy_indicator_out,
  output logic            text_clear_out
);
  localparam int CW = cgm_pkg::CGM_CNT_W;

  initial begin
    if (INIT_CYCLES < 8 || INIT_CYCLES >= 2**CW) $error("INIT_CYCLES out of range");
  end

  cgm_pkg::cgm_state_t state_r;
  cgm_pkg::cgm_state_t state_nxt;
  logic [CW-1:0]       cnt_r;
  logic [CW-1:0]       cnt_nxt;
  logic                busy_r;
  logic                busy_nxt;
  logic                clear_r;
  logic                clear_nxt;

  logic [7:0]          ctrl_r;
  logic [7:0]          ctrl_nxt;
  logic [5:0]          gaddr_r;
  logic [5:0]          gaddr_nxt;
  logic                sel_r;
  logic                sel_nxt;
  logic [7:0]          rdata_r;
  logic [7:0]          rdata_nxt;
  logic                ram_we;
  logic [7:0]          ram_a_q;
  logic [7:0]          ram_b_q;
  logic [5:0]          ram_b_addr;

  logic                s1_user_r;
  logic                s1_user_nxt;
  logic                s1_row7_r;
  logic                s1_row7_nxt;
  logic                s1_cur_r;
  logic                s1_cur_nxt;
  logic [7:0]          s1_code_r;
  logic [7:0]          s1_code_nxt;
  logic [4:0]          dots_r;
  logic [4:0]          dots_nxt;
  logic                rom_r;
  logic                rom_nxt;
  logic [7:0]          rom_code_r;
  logic [7:0]          rom_code_nxt;

  // power-on sequence
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    clear_nxt = 1'b0;
    unique case (state_r)
      cgm_pkg::CGM_ST_CLEAR: begin
        clear_nxt = 1'b1;
        state_nxt = cgm_pkg::CGM_ST_FUNC;
      end
      cgm_pkg::CGM_ST_FUNC:  state_nxt = cgm_pkg::CGM_ST_DISP;
      cgm_pkg::CGM_ST_DISP:  state_nxt = cgm_pkg::CGM_ST_ENTRY;
      cgm_pkg::CGM_ST_ENTRY: state_nxt = cgm_pkg::CGM_ST_WAIT;
      cgm_pkg::CGM_ST_WAIT: begin
        if (cnt_r == CW'(INIT_CYCLES - 1)) begin
          state_nxt = cgm_pkg::CGM_ST_IDLE;
        end
      end
      cgm_pkg::CGM_ST_IDLE:  state_nxt = cgm_pkg::CGM_ST_IDLE;
      default:               state_nxt = cgm_pkg::CGM_ST_CLEAR;
    endcase
    if (state_r != cgm_pkg::CGM_ST_IDLE) begin
      cnt_nxt = cnt_r + CW'(1);
    end
    busy_nxt = (state_nxt != cgm_pkg::CGM_ST_IDLE);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= cgm_pkg::CGM_ST_CLEAR;
      cnt_r   <= '0;
      busy_r  <= 1'b1;
      clear_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      busy_r  <= busy_nxt;
      clear_r <= clear_nxt;
    end
  end

  // register port; writes and data-port side effects are refused while busy
  always_comb begin
    logic       wr_ok;
    logic       dat_acc;
    logic [5:0] step;
    wr_ok     = reg_wr_in && !busy_r;
    dat_acc   = !busy_r && sel_r && (reg_addr_in == cgm_pkg::CGM_OFF_GLYPH_DAT) && (reg_wr_in || reg_rd_in);
    step      = ctrl_r[cgm_pkg::CGM_CTRL_INC] ? 6'h01 : 6'h3F;
    ctrl_nxt  = ctrl_r;
    gaddr_nxt = gaddr_r;
    sel_nxt   = sel_r;
    rdata_nxt = rdata_r;
    ram_we    = dat_acc && reg_wr_in;
    unique case (state_r)
      cgm_pkg::CGM_ST_FUNC: begin
        // 8-bit bus, one line, 5x7 font
        ctrl_nxt[cgm_pkg::CGM_CTRL_BUSW]  = 1'b1;
        ctrl_nxt[cgm_pkg::CGM_CTRL_LINES] = 1'b0;
        ctrl_nxt[cgm_pkg::CGM_CTRL_FONT]  = 1'b0;
      end
      cgm_pkg::CGM_ST_DISP: begin
        ctrl_nxt[cgm_pkg::CGM_CTRL_DISP]   = 1'b0;
        ctrl_nxt[cgm_pkg::CGM_CTRL_CURSOR] = 1'b0;
        ctrl_nxt[cgm_pkg::CGM_CTRL_BLINK]  = 1'b0;
      end
      cgm_pkg::CGM_ST_ENTRY: begin
        ctrl_nxt[cgm_pkg::CGM_CTRL_INC]   = 1'b1;
        ctrl_nxt[cgm_pkg::CGM_CTRL_SHIFT] = 1'b0;
      end
      cgm_pkg::CGM_ST_WAIT: begin
        sel_nxt = 1'b0;
      end
      default: begin
        if (wr_ok && reg_addr_in == cgm_pkg::CGM_OFF_CTRL) begin
          ctrl_nxt = reg_wdata_in;
        end
        if (wr_ok && reg_addr_in == cgm_pkg::CGM_OFF_GLYPH_ADR) begin
          gaddr_nxt = reg_wdata_in[5:0];
          sel_nxt   = 1'b1;
        end
        if (wr_ok && reg_addr_in == cgm_pkg::CGM_OFF_RAM_SEL) begin
          sel_nxt = reg_wdata_in[0];
        end
        if (dat_acc) begin
          gaddr_nxt = gaddr_r + step;
        end
      end
    endcase
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        cgm_pkg::CGM_OFF_STATUS:    rdata_nxt = {busy_r, sel_r, gaddr_r};
        cgm_pkg::CGM_OFF_CTRL:      rdata_nxt = ctrl_r;
        cgm_pkg::CGM_OFF_GLYPH_ADR: rdata_nxt = {2'h0, gaddr_r};
        // all eight stored bits read back
        cgm_pkg::CGM_OFF_GLYPH_DAT: rdata_nxt = sel_r ? ram_a_q : 8'h00;
        cgm_pkg::CGM_OFF_RAM_SEL:   rdata_nxt = {7'h00, sel_r};
        default:                    rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r  <= cgm_pkg::CGM_CTRL_RST;
      gaddr_r <= cgm_pkg::CGM_GADDR_RST;
      sel_r   <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r  <= ctrl_nxt;
      gaddr_r <= gaddr_nxt;
      sel_r   <= sel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // code bits 2..0 above row, bit 3 dropped
  assign ram_b_addr = {char_code_in[2:0], pat_row_in};

  // port a reads the next address so its data is ready for a read strobe
  cgm_glyph_ram #(
    .AW (6),
    .DW (8)
  ) u_ram (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .wr_en_in      (ram_we),
    .wr_addr_in    (gaddr_r),
    .wr_data_in    (reg_wdata_in),
    .rd_a_addr_in  (gaddr_nxt),
    .rd_a_data_out (ram_a_q),
    .rd_b_addr_in  (ram_b_addr),
    .rd_b_data_out (ram_b_q)
  );

  // glyph fetch pipeline, two cycles
  always_comb begin
    logic [4:0] cur_mask;
    cur_mask = (s1_row7_r && s1_cur_r && ctrl_r[cgm_pkg::CGM_CTRL_CURSOR]) ? cgm_pkg::CGM_ROW_ALL : 5'h00;
    // user glyphs only for codes with bits 7..4 zero
    s1_user_nxt  = (char_code_in[7:4] == 4'h0);
    s1_row7_nxt  = (pat_row_in == cgm_pkg::CGM_CURSOR_ROW);
    s1_cur_nxt   = cursor_here_in;
    s1_code_nxt  = char_code_in;
    dots_nxt     = 5'h00;
    rom_nxt      = 1'b0;
    rom_code_nxt = s1_code_r;
    if (ctrl_r[cgm_pkg::CGM_CTRL_DISP]) begin
      if (s1_user_r) begin
        // bits 4..0 lit on one, cursor ORed in
        dots_nxt = ram_b_q[4:0] | cur_mask;
      end else begin
        // ROM font supplies the pattern, only cursor here
        rom_nxt  = 1'b1;
        dots_nxt = cur_mask;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_user_r  <= 1'b0;
      s1_row7_r  <= 1'b0;
      s1_cur_r   <= 1'b0;
      s1_code_r  <= 8'h00;
      dots_r     <= 5'h00;
      rom_r      <= 1'b0;
      rom_code_r <= 8'h00;
    end else begin
      s1_user_r  <= s1_user_nxt;
      s1_row7_r  <= s1_row7_nxt;
      s1_cur_r   <= s1_cur_nxt;
      s1_code_r  <= s1_code_nxt;
      dots_r     <= dots_nxt;
      rom_r      <= rom_nxt;
      rom_code_r <= rom_code_nxt;
    end
  end

  assign reg_rdata_out      = rdata_r;
  assign dots_out           = dots_r;
  assign rom_glyph_out      = rom_r;
  assign rom_code_out       = rom_code_r;
  assign busy_indicator_out = busy_r;
  assign text_clear_out     = clear_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_busy_hold: assert property (
    (state_r != cgm_pkg::CGM_ST_IDLE) |-> busy_indicator_out)
    else $error("busy low during init");

  a_busy_end: assert property (
    (state_r == cgm_pkg::CGM_ST_WAIT && cnt_r == CW'(INIT_CYCLES - 1)) |=> !busy_indicator_out ##1 !busy_indicator_out)
    else $error("busy did not clear at end of init");

  a_init_func: assert property (
    $fell(busy_indicator_out) |-> (ctrl_r[7:5] == 3'h4))
    else $error("function bits wrong after init");

  a_init_disp: assert property (
    $fell(busy_indicator_out) |-> (ctrl_r[2:0] == 3'h0))
    else $error("display control wrong after init");

  a_init_entry: assert property (
    $fell(busy_indicator_out) |-> (ctrl_r[4:3] == 2'h2))
    else $error("entry mode wrong after init");

  a_text_sel: assert property (
    $fell(busy_indicator_out) |-> !sel_r && $past(text_clear_out, 2) == 1'b0)
    else $error("text memory not selected after init");

  a_clear_first: assert property (
    (state_r == cgm_pkg::CGM_ST_CLEAR) |=> text_clear_out ##1 !text_clear_out)
    else $error("clear pulse missing");

  a_rom_select: assert property (
    (char_code_in[7:4] != 4'h0 && pat_row_in != cgm_pkg::CGM_CURSOR_ROW) ##1 ctrl_r[cgm_pkg::CGM_CTRL_DISP]
    |=> rom_glyph_out && dots_out == 5'h00)
    else $error("ROM code shown from user memory");

  a_cursor_or: assert property (
    (s1_row7_r && s1_cur_r && ctrl_r[cgm_pkg::CGM_CTRL_CURSOR] && ctrl_r[cgm_pkg::CGM_CTRL_DISP])
    |=> dots_out == cgm_pkg::CGM_ROW_ALL)
    else $error("cursor not ORed into eighth row");

  a_row7_lit: assert property (
    (s1_row7_r && s1_user_r && ctrl_r[cgm_pkg::CGM_CTRL_DISP])
    |=> ((dots_out & $past(ram_b_q[4:0])) == $past(ram_b_q[4:0])))
    else $error("stored eighth row dot dark");

  a_user_dots: assert property (
    (!s1_row7_r && s1_user_r && ctrl_r[cgm_pkg::CGM_CTRL_DISP])
    |=> dots_out == $past(ram_b_q[4:0]) && !rom_glyph_out)
    else $error("user dots differ from stored bits");

  a_write_refused: assert property (
    (busy_indicator_out && reg_wr_in && reg_addr_in == cgm_pkg::CGM_OFF_CTRL
      && state_r == cgm_pkg::CGM_ST_WAIT) |=> $stable(ctrl_r))
    else $error("control written while busy");

  a_addr_step: assert property (
    (!busy_indicator_out && sel_r && reg_addr_in == cgm_pkg::CGM_OFF_GLYPH_DAT && (reg_wr_in || reg_rd_in))
    |=> gaddr_r == $past(gaddr_r) + ($past(ctrl_r[cgm_pkg::CGM_CTRL_INC]) ? 6'h01 : 6'h3F))
    else $error("glyph address did not step");

  c_init_done: cover property ($fell(busy_indicator_out));
  c_user_row:  cover property (s1_user_r && ctrl_r[cgm_pkg::CGM_CTRL_DISP] ##1 dots_out != 5'h00);
  c_cursor:    cover property (s1_row7_r && s1_cur_r && ctrl_r[cgm_pkg::CGM_CTRL_CURSOR]);
  c_data_rw:   cover property (ram_we ##[1:2] reg_rd_in && reg_addr_in == cgm_pkg::CGM_OFF_GLYPH_DAT);
endmodule : cgm_ctrl

/* File: dv/cgm_host_model.sv */
// host model: drives the register port of the glyph map controller
// assumes it shares sys_clk with the controller
module cgm_host_model (
  input  wire logic       sys_clk_in,
  input  wire logic       busy_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge sys_clk_in);
    wr_out    <= 1'b0;
    // idle bus shows inverted values so stale data cannot match
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge sys_clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask : rd
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge sys_clk_in);
      #1;
      ok = (busy_in === 1'b0);
    end
  endtask : wait_ready
endmodule : cgm_host_model

/* File: dv/cgm_ctrl_tb_top.sv */
// self-checking bench for the glyph map controller
// assumes a shortened power-on count; host model drives the register port
module cgm_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT = 16;
  logic       sys_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic [7:0] code    = 8'h00;
  logic [2:0] row     = 3'h0;
  logic       cur     = 1'b0;
  logic [7:0] addr, wdata, rdata, romc;
  logic       wr, rd, busy, tclr, rom;
  logic [4:0] dots;
  int         fail_count   = 0;
  int         total_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  cgm_ctrl #(.INIT_CYCLES(INIT)) dut (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .char_code_in(code),
    .pat_row_in(row), .cursor_here_in(cur), .dots_out(dots), .rom_glyph_out(rom),
    .rom_code_out(romc), .busy_indicator_out(busy), .text_clear_out(tclr));
  cgm_host_model host (
    .sys_clk_in(sys_clk), .busy_in(busy), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val
  task automatic chk_flag(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk_flag
  // bits 7..5 vary so spare storage is exercised; glyph 0 row 7 kept clear
  function automatic logic [7:0] pat(input int a);
    return (a == 7) ? 8'h00 : 8'(a) * 8'h25 + 8'h13;
  endfunction : pat
  task automatic test_init();
    int         clr;
    logic [7:0] d;
    clr = 0;
    repeat (20) @(posedge sys_clk);
    chk_flag("busy_in_reset", 1'b1, busy);
    rst_n <= 1'b1;
    for (int e = 1; e <= INIT + 1; e++) begin
      @(posedge sys_clk);
      #1;
      if (tclr === 1'b1) clr++;
      if (e < INIT) chk_flag("busy_init", 1'b1, busy);
      if (e == INIT) chk_flag("busy_fall", 1'b0, busy);
      if (e == INIT / 2) begin
        // write while busy must leave no trace
        host.wr(cgm_pkg::CGM_OFF_CTRL, 8'hFF);
        e += 2;
        #1;
      end
    end
    chk_flag("busy_done", 1'b0, busy);
    chk_val("clear_pulses", 8'h01, 8'(clr));
    host.rd(cgm_pkg::CGM_OFF_CTRL, d);
    chk_val("ctrl_init", 8'h90, d);
    host.rd(cgm_pkg::CGM_OFF_STATUS, d);
    chk_val("status_init", 8'h00, d);
    $display("test init done");
  endtask : test_init
  task automatic test_glyph();
    logic [7:0] d;
    host.wr(cgm_pkg::CGM_OFF_GLYPH_ADR, 8'h00);
    for (int a = 0; a < 64; a++) host.wr(cgm_pkg::CGM_OFF_GLYPH_DAT, pat(a));
    host.rd(cgm_pkg::CGM_OFF_STATUS, d);
    chk_val("status_wrap", 8'h40, d);
    host.wr(cgm_pkg::CGM_OFF_GLYPH_ADR, 8'h00);
    for (int a = 0; a < 64; a++) begin
      host.rd(cgm_pkg::CGM_OFF_GLYPH_DAT, d);
      chk_val("glyph_rd", pat(a), d);
    end
    host.wr(cgm_pkg::CGM_OFF_GLYPH_ADR, 8'h08);
    host.rd(cgm_pkg::CGM_OFF_STATUS, d);
    chk_val("status_adr", 8'h48, d);
    host.wr(cgm_pkg::CGM_OFF_RAM_SEL, 8'h00);
    host.rd(cgm_pkg::CGM_OFF_GLYPH_DAT, d);
    chk_val("text_sel_rd", 8'h00, d);
    host.rd(8'h20, d);
    chk_val("unmapped", 8'h00, d);
    host.rd(cgm_pkg::CGM_OFF_STATUS, d);
    chk_val("status_sel0", 8'h08, d);
    $display("test glyph done");
  endtask : test_glyph
  task automatic render(input logic [7:0] ctl, input logic [7:0] c, input logic [2:0] r, input logic cu);
    logic [4:0] m;
    logic [4:0] e;
    logic       user;
    @(posedge sys_clk);
    code <= c;
    row  <= r;
    cur  <= cu;
    repeat (2) @(posedge sys_clk);
    #1;
    user = (c[7:4] == 4'h0);
    m = (r == 3'h7 && cu && ctl[1]) ? 5'h1F : 5'h00;
    e = !ctl[2] ? 5'h00 : user ? 5'(pat({c[2:0], r})) | m : m;
    chk_val("dots", {3'h0, e}, {3'h0, dots});
    chk_flag("rom_glyph", ctl[2] && !user, rom);
    chk_val("rom_code", c, romc);
  endtask : render
  task automatic test_render();
    logic [7:0] rc [3] = '{8'h10, 8'hA7, 8'hF8};
    host.wr(cgm_pkg::CGM_OFF_CTRL, 8'h96);
    for (int c = 0; c < 16; c++) begin
      for (int r = 0; r < 8; r++) render(8'h96, 8'(c), 3'(r), c[0] ^ r[0]);
    end
    foreach (rc[i]) begin
      render(8'h96, rc[i], 3'h7, 1'b1);
      render(8'h96, rc[i], 3'h3, 1'b0);
    end
    host.wr(cgm_pkg::CGM_OFF_CTRL, 8'h94);
    render(8'h94, 8'h00, 3'h7, 1'b1);
    host.wr(cgm_pkg::CGM_OFF_CTRL, 8'h92);
    render(8'h92, 8'h00, 3'h2, 1'b0);
    render(8'h92, 8'h41, 3'h7, 1'b1);
    $display("test render done");
  endtask : test_render
  // decrement stepping, host init by instructions, then a reset in mid-run
  task automatic test_reinit();
    logic [7:0] d;
    int         n;
    host.wr(cgm_pkg::CGM_OFF_CTRL, 8'h80);
    host.wr(cgm_pkg::CGM_OFF_GLYPH_ADR, 8'h05);
    host.wr(cgm_pkg::CGM_OFF_GLYPH_DAT, 8'hA5);
    host.rd(cgm_pkg::CGM_OFF_GLYPH_DAT, d);
    chk_val("dec_rd", pat(4), d);
    host.rd(cgm_pkg::CGM_OFF_STATUS, d);
    chk_val("dec_status", 8'h43, d);
    host.wr(cgm_pkg::CGM_OFF_GLYPH_ADR, 8'h05);
    host.rd(cgm_pkg::CGM_OFF_GLYPH_DAT, d);
    chk_val("spare_bits", 8'hA5, d);
    host.wr(cgm_pkg::CGM_OFF_CTRL, 8'h90);
    host.wr(cgm_pkg::CGM_OFF_RAM_SEL, 8'h00);
    host.rd(cgm_pkg::CGM_OFF_CTRL, d);
    chk_val("ctrl_by_instr", 8'h90, d);
    host.rd(cgm_pkg::CGM_OFF_STATUS, d);
    chk_val("status_by_instr", 8'h04, d);
    host.wr(cgm_pkg::CGM_OFF_CTRL, 8'h7F);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk_flag("busy_rerun", 1'b1, busy);
    chk_val("rdata_reset", 8'h00, rdata);
    rst_n <= 1'b1;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk_val("rerun_len", 8'(INIT), 8'(n));
    host.rd(cgm_pkg::CGM_OFF_CTRL, d);
    chk_val("ctrl_rerun", 8'h90, d);
    host.rd(cgm_pkg::CGM_OFF_STATUS, d);
    chk_val("status_rerun", 8'h00, d);
    $display("test reinit done");
  endtask : test_reinit
  initial begin
    logic ok;
    test_init();
    host.wait_ready(ok);
    if (!ok) begin
      fail_count++;
    end else begin
      test_glyph();
      test_render();
      test_reinit();
    end
    end_sim();
  end
endmodule : cgm_ctrl_tb_top
